// *** core/eeprom_defs.vh ***
// constants and functional notes for the i2c serial eeprom target
// Functional notes
// - reset holds logic idle; after release device powers into standby.
// - sample data on clock rise, change output after fall, drive low only.
// - start is data fall with clock high; stop is data rise, ends command.
// - without a start all traffic is ignored and nothing is acknowledged.
// - respond only when address top bits are 1010 plus three strap levels.
// - eighth address bit one means read, zero means write.
// - ninth clock is acknowledge; receiver pulls low to ack, leaves high not.
// - byte write is address, two memory address bytes, data, stop; all acked.
// - stop after data starts programming; then no drive and no address ack.
// - up to 32 data bytes load a page buffer from the supplied address.
// - page part stays latched; byte counter wraps within the page.
// - after stop all buffered bytes commit in one programming cycle.
// - write protect high blocks all writes; low has no effect.
// - write protect sampled before first data byte; high declines and discards.
// - array starts with every byte reading all ones.
// - read with no address load returns byte at the current address.
// - master ends read with no-ack then stop; device returns to standby.
// - random read loads address by write, repeated start, then reads there.
// - master ack on a read byte makes the device send the next byte.
// - sequential read address crosses pages and wraps from top to zero.
// - programming cycle ends within 4 ms for byte and page alike.
// - device accepts commands within 0.35 ms after supply is stable.
`ifndef EEPROM_DEFS_VH
`define EEPROM_DEFS_VH

`define DEV_CODE 4'ha
`define ERASED_BYTE 8'hff
`define MEM_BYTES 8192
`define PAGE_BYTES 32
`define FIFO_DEPTH 4
`define CLK_PERIOD_NS 10
`define T_WR_NS 4000000
`define T_PU_NS 350000
`define WR_CYCLES 19'h61a80 // 4 ms over the 10 ns clock, sized for the 19-bit counter
`define PU_CYCLES 16'h88b8 // 0.35 ms over the 10 ns clock, sized for the 16-bit counter

`define ST_IDLE 3'h0
`define ST_DEV 3'h1
`define ST_AH 3'h2
`define ST_AL 3'h3
`define ST_WR 3'h4
`define ST_RD 3'h5

`endif

// *** core/i2c_eeprom_slave.v ***
// i2c serial eeprom target: bus protocol, page buffer, commit fifo, array
`include "eeprom_defs.vh"
`default_nettype none

// small fifo; depth must be a power of two so the pointers wrap by themselves
module commit_fifo #(
    parameter WIDTH = 21,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire core_clk,
    input wire rst_n,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    localparam [AW:0] FULL_COUNT = DEPTH[AW:0];
    localparam [AW-1:0] PTR_ONE = {{(AW-1){1'b0}}, 1'b1};
    localparam [AW:0] CNT_ONE = {{AW{1'b0}}, 1'b1};

    reg [WIDTH-1:0] slot [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;

    assign in_ready = (count_reg != FULL_COUNT);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data = slot[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage carries no reset; only the pointers and the fill count need a defined value
    always @(posedge core_clk) begin
        if (push) begin
            slot[wr_ptr_reg] <= in_data;
        end
    end

    // pointers and fill count
    always @(posedge core_clk) begin
        if (!rst_n) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + PTR_ONE;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + PTR_ONE;
            end
            if (push && !pop) begin
                count_reg <= count_reg + CNT_ONE;
            end else if (pop && !push) begin
                count_reg <= count_reg - CNT_ONE;
            end
        end
    end
endmodule // commit_fifo

module i2c_eeprom_slave #(
    parameter [18:0] WR_CYCLES = `WR_CYCLES,
    parameter [15:0] PU_CYCLES = `PU_CYCLES
) (
    input wire core_clk,
    input wire rst_n,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe_n,
    input wire strap_sel_bit0,
    input wire strap_sel_bit1,
    input wire strap_sel_bit2,
    input wire wp_in,
    output reg write_busy,
    output reg dev_ready
);
    reg [7:0] mem [0:`MEM_BYTES-1];
    reg [7:0] page_buf [0:`PAGE_BYTES-1];
    integer i;

    // two-flop synchronisers for every pin input
    reg scl_meta_reg, scl_sync_reg, scl_prev_reg;
    reg sda_meta_reg, sda_sync_reg, sda_prev_reg;
    reg [2:0] strap_meta_reg, strap_sync_reg;
    reg wp_meta_reg, wp_sync_reg;

    reg [2:0] state_reg;
    reg [2:0] nxt_reg;
    reg [3:0] bit_cnt_reg;
    reg ack_phase_reg;
    reg [7:0] shift_reg;
    reg [7:0] addr_hi_reg;
    reg [12:0] cur_addr_reg;
    reg mack_reg;
    reg wp_lat_reg;
    reg [31:0] dirty_reg;
    reg commit_go_reg;
    reg [7:0] rd_byte_reg;

    reg [15:0] pu_cnt_reg;
    reg [18:0] wr_cnt_reg;
    reg [5:0] idx_reg;
    reg [7:0] page_reg;
    reg drain_slot_reg;

    wire scl_rise, scl_fall, start_det, stop_det, addr_match;
    wire fifo_in_valid, fifo_in_ready, fifo_out_valid;
    wire [20:0] fifo_out_data;
    wire wr_done;

    // bus events from the synchronised levels only
    assign scl_rise = scl_sync_reg && !scl_prev_reg;
    assign scl_fall = !scl_sync_reg && scl_prev_reg;
    assign start_det = scl_sync_reg && scl_prev_reg && sda_prev_reg && !sda_sync_reg;
    assign stop_det = scl_sync_reg && scl_prev_reg && !sda_prev_reg && sda_sync_reg;
    // busy or not yet ready means the address is never acknowledged
    assign addr_match = (shift_reg[7:4] == `DEV_CODE)
        && (shift_reg[3:1] == strap_sync_reg) && dev_ready && !write_busy;

    // erased array at start of life
    initial begin
        for (i = 0; i < `MEM_BYTES; i = i + 1) begin
            mem[i] = `ERASED_BYTE;
        end
    end

    // synchronisers; first stage is read only by the second
    always @(posedge core_clk) begin
        if (!rst_n) begin
            scl_meta_reg <= 1'b1;
            scl_sync_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            strap_meta_reg <= 3'h0;
            strap_sync_reg <= 3'h0;
            wp_meta_reg <= 1'b0;
            wp_sync_reg <= 1'b0;
        end else begin
            scl_meta_reg <= scl_in;
            scl_sync_reg <= scl_meta_reg;
            scl_prev_reg <= scl_sync_reg;
            sda_meta_reg <= sda_in;
            sda_sync_reg <= sda_meta_reg;
            sda_prev_reg <= sda_sync_reg;
            strap_meta_reg <= {strap_sel_bit2, strap_sel_bit1, strap_sel_bit0};
            strap_sync_reg <= strap_meta_reg;
            wp_meta_reg <= wp_in;
            wp_sync_reg <= wp_meta_reg;
        end
    end

    // power-up delay; reset re-enters here, so a brown-out restarts it
    always @(posedge core_clk) begin
        if (!rst_n) begin
            pu_cnt_reg <= 16'h0000;
            dev_ready <= 1'b0;
        end else if (!dev_ready) begin
            pu_cnt_reg <= pu_cnt_reg + 16'h0001;
            if (pu_cnt_reg == PU_CYCLES - 16'h0001) begin
                dev_ready <= 1'b1;
            end
        end
    end

    // protocol engine; rd_byte tracks the current address every cycle
    always @(posedge core_clk) begin
        rd_byte_reg <= mem[cur_addr_reg];
        if (!rst_n) begin
            state_reg <= `ST_IDLE;
            nxt_reg <= `ST_IDLE;
            bit_cnt_reg <= 4'h0;
            ack_phase_reg <= 1'b0;
            shift_reg <= 8'h00;
            addr_hi_reg <= 8'h00;
            cur_addr_reg <= 13'h0000;
            mack_reg <= 1'b1;
            wp_lat_reg <= 1'b0;
            dirty_reg <= 32'h00000000;
            commit_go_reg <= 1'b0;
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
        end else begin
            commit_go_reg <= 1'b0;
            sda_out <= 1'b0; // only ever pulls low
            if (start_det) begin
                state_reg <= `ST_DEV;
                bit_cnt_reg <= 4'h0;
                ack_phase_reg <= 1'b0;
                sda_oe_n <= 1'b1;
            end else if (stop_det) begin
                state_reg <= `ST_IDLE;
                ack_phase_reg <= 1'b0;
                sda_oe_n <= 1'b1;
                if (state_reg == `ST_WR && |dirty_reg && !write_busy) begin
                    commit_go_reg <= 1'b1;
                end
            end else if (state_reg == `ST_IDLE) begin
                sda_oe_n <= 1'b1; // idle ignores everything but a start
            end else if (scl_rise) begin
                if (bit_cnt_reg != 4'h8) begin
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (state_reg != `ST_RD) begin
                        shift_reg <= {shift_reg[6:0], sda_sync_reg};
                    end
                end else if (ack_phase_reg && state_reg == `ST_RD) begin
                    mack_reg <= sda_sync_reg;
                    cur_addr_reg <= cur_addr_reg + 13'h0001;
                end
            end else if (scl_fall) begin
                if (bit_cnt_reg == 4'h8 && !ack_phase_reg) begin
                    ack_phase_reg <= 1'b1;
                    case (state_reg)
                        `ST_DEV: begin
                            if (addr_match) begin
                                sda_oe_n <= 1'b0;
                                nxt_reg <= shift_reg[0] ? `ST_RD : `ST_AH;
                                if (!shift_reg[0]) begin
                                    dirty_reg <= 32'h00000000;
                                end
                            end else begin
                                sda_oe_n <= 1'b1;
                                nxt_reg <= `ST_IDLE;
                            end
                        end
                        `ST_AH: begin
                            addr_hi_reg <= shift_reg;
                            sda_oe_n <= 1'b0;
                            nxt_reg <= `ST_AL;
                        end
                        `ST_AL: begin
                            // upper three address bits are dropped
                            cur_addr_reg <= {addr_hi_reg[4:0], shift_reg};
                            sda_oe_n <= 1'b0;
                            nxt_reg <= `ST_WR;
                        end
                        `ST_WR: begin
                            if (wp_lat_reg) begin
                                sda_oe_n <= 1'b1;
                                nxt_reg <= `ST_IDLE;
                            end else begin
                                page_buf[cur_addr_reg[4:0]] <= shift_reg;
                                dirty_reg[cur_addr_reg[4:0]] <= 1'b1;
                                cur_addr_reg[4:0] <= cur_addr_reg[4:0] + 5'h01;
                                sda_oe_n <= 1'b0;
                                nxt_reg <= `ST_WR;
                            end
                        end
                        `ST_RD: begin
                            sda_oe_n <= 1'b1; // release for the master
                            nxt_reg <= `ST_RD;
                        end
                        default: begin
                            sda_oe_n <= 1'b1;
                            nxt_reg <= `ST_IDLE;
                        end
                    endcase
                end else if (ack_phase_reg) begin
                    ack_phase_reg <= 1'b0;
                    bit_cnt_reg <= 4'h0;
                    if (state_reg == `ST_AL) begin
                        wp_lat_reg <= wp_sync_reg;
                    end
                    if (nxt_reg == `ST_RD && (state_reg != `ST_RD || !mack_reg)) begin
                        state_reg <= `ST_RD;
                        shift_reg <= {rd_byte_reg[6:0], 1'b1};
                        sda_oe_n <= rd_byte_reg[7];
                    end else if (state_reg == `ST_RD) begin
                        state_reg <= `ST_IDLE;
                        sda_oe_n <= 1'b1;
                    end else begin
                        state_reg <= nxt_reg;
                        sda_oe_n <= 1'b1;
                    end
                end else if (state_reg == `ST_RD) begin
                    if (bit_cnt_reg == 4'h0) begin
                        sda_oe_n <= 1'b1;
                    end else begin
                        sda_oe_n <= shift_reg[7];
                        shift_reg <= {shift_reg[6:0], 1'b1};
                    end
                end
            end
        end
    end

    // commit: push dirty page entries, stall on fifo ready, time the cycle
    assign fifo_in_valid = write_busy && !idx_reg[5] && dirty_reg[idx_reg[4:0]];
    assign wr_done = (wr_cnt_reg == WR_CYCLES - 19'h00001);

    always @(posedge core_clk) begin
        if (!rst_n) begin
            write_busy <= 1'b0;
            idx_reg <= 6'h00;
            wr_cnt_reg <= 19'h00000;
            page_reg <= 8'h00;
        end else if (commit_go_reg) begin
            write_busy <= 1'b1;
            idx_reg <= 6'h00;
            wr_cnt_reg <= 19'h00000;
            page_reg <= cur_addr_reg[12:5];
        end else if (write_busy) begin
            if (!wr_done) begin
                wr_cnt_reg <= wr_cnt_reg + 19'h00001;
            end
            if (!idx_reg[5] && (!fifo_in_valid || fifo_in_ready)) begin
                idx_reg <= idx_reg + 6'h01;
            end
            if (wr_done && idx_reg[5] && !fifo_out_valid) begin
                write_busy <= 1'b0;
            end
        end
    end

    // array accepts one write every other cycle, so the fifo really fills
    always @(posedge core_clk) begin
        if (!rst_n) begin
            drain_slot_reg <= 1'b0;
        end else begin
            drain_slot_reg <= !drain_slot_reg;
        end
    end

    always @(posedge core_clk) begin
        if (fifo_out_valid && drain_slot_reg) begin
            mem[fifo_out_data[20:8]] <= fifo_out_data[7:0];
        end
    end

    commit_fifo #(
        .WIDTH(21),
        .DEPTH(`FIFO_DEPTH),
        .AW(2)
    ) u_commit_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_data({page_reg, idx_reg[4:0], page_buf[idx_reg[4:0]]}),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(drain_slot_reg)
    );
endmodule // i2c_eeprom_slave

`default_nettype wire

// *** sim/i2c_eeprom_slave_asserts.sv ***
// port-level checks for the i2c eeprom target
`default_nettype none
module i2c_eeprom_slave_asserts #(
    parameter [18:0] WR_CYCLES = 19'h000c8,
    parameter [15:0] PU_CYCLES = 16'h0014
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic write_busy,
    input wire logic dev_ready
);
    logic [15:0] up_cnt;
    logic [18:0] busy_len;
    logic sda_q;
    logic idle_reg;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // raw start/stop on the pins is seen ahead of the design's synchroniser
    always @(posedge core_clk) begin
        sda_q <= sda_in;
        if (!rst_n) begin
            up_cnt <= 16'h0000;
            busy_len <= 19'h00000;
            idle_reg <= 1'b1;
        end else begin
            up_cnt <= (up_cnt == 16'hffff) ? up_cnt : up_cnt + 16'h0001; // saturate, no wrap
            busy_len <= write_busy ? busy_len + 19'h00001 : 19'h00000;
            if (scl_in && sda_q != sda_in) begin
                idle_reg <= sda_in; // rise is a stop, fall a start
            end
        end
    end
    property p_reset_vals; $rose(rst_n) |-> sda_oe_n && !write_busy && !dev_ready; endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("outputs not idle after reset");
    property p_low_only; sda_out == 1'b0; endproperty
    a_low_only: assert property (p_low_only) else $error("data driven high");
    property p_scl_low; $changed(sda_oe_n) |-> !scl_in; endproperty
    a_scl_low: assert property (p_scl_low) else $error("data moved with clock high");
    property p_no_start; idle_reg |-> sda_oe_n; endproperty
    a_no_start: assert property (p_no_start) else $error("drive without a start");
    property p_pu_early; (up_cnt < PU_CYCLES - 16'h0001) |-> !dev_ready; endproperty
    a_pu_early: assert property (p_pu_early) else $error("ready too early");
    property p_pu_late; (up_cnt > PU_CYCLES + 16'h0001) |-> dev_ready; endproperty
    a_pu_late: assert property (p_pu_late) else $error("ready too late");
    property p_busy_quiet; write_busy |-> sda_oe_n; endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy");
    property p_busy_len;
        $fell(write_busy) |-> busy_len >= WR_CYCLES - 1 && busy_len <= WR_CYCLES + 1;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
endmodule // i2c_eeprom_slave_asserts
bind i2c_eeprom_slave i2c_eeprom_slave_asserts #(.WR_CYCLES(WR_CYCLES), .PU_CYCLES(PU_CYCLES))
    chk_inst (.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .write_busy(write_busy), .dev_ready(dev_ready));
`default_nettype wire

// *** sim/bus_master.sv ***
// behavioural i2c bus master driving the link clock and data
`default_nettype none
module bus_master (
    output var logic scl,
    output var logic sda_drv,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    // clock stands high between frames, data left to the pull-up
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // data moves 20 ns after the fall and holds through the high phase
    task automatic clk_bit(input logic b, output logic r);
        sda_drv = b;
        #62.5 scl = 1'b1;
        #62.5 r = sda;
        scl = 1'b0;
        #20;
    endtask
    task automatic start();
        sda_drv = 1'b1;
        #62.5 scl = 1'b1;
        #62.5 sda_drv = 1'b0; // falls with clock high
        #62.5 scl = 1'b0;
        #20;
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        #62.5 scl = 1'b1;
        #62.5 sda_drv = 1'b1; // rises with clock high
        #62.5;
    endtask
    // line released on the ninth clock for the target's answer
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
        clk_bit(1'b1, r);
        ack = !r;
    endtask
    // ack asks for more, no-ack ends the read
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) begin
            clk_bit(1'b1, r);
            d = {d[6:0], r};
        end
        clk_bit(!mack, r);
    endtask
endmodule // bus_master
`default_nettype wire

// *** sim/i2c_eeprom_slave_bench.sv ***
// self-checking bench for the i2c eeprom target
`default_nettype none
`include "eeprom_defs.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module i2c_eeprom_slave_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] DEV_W = {`DEV_CODE, 3'h5, 1'b0};
    localparam logic [7:0] DEV_R = {`DEV_CODE, 3'h5, 1'b1};
    logic core_clk, rst_n, wp_lvl;
    logic [2:0] strap_lvl;
    wire logic scl, sda_drv, sda_out, sda_oe_n, write_busy, dev_ready;
    logic [7:0] got[$];
    int n_checks, err_total;
    // pulled-up open-drain wire: any party pulling low wins
    wire logic sda = sda_drv & (sda_oe_n | sda_out);
    bus_master bus_master_inst (.scl(scl), .sda_drv(sda_drv), .sda(sda));
    i2c_eeprom_slave #(.WR_CYCLES(19'h000c8), .PU_CYCLES(16'h0014)) i2c_eeprom_slave_inst (
        .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .strap_sel_bit0(strap_lvl[0]), .strap_sel_bit1(strap_lvl[1]),
        .strap_sel_bit2(strap_lvl[2]), .wp_in(wp_lvl), .write_busy(write_busy),
        .dev_ready(dev_ready));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic power_up();
        @(posedge core_clk) rst_n <= 1'b0;
        repeat (16) @(posedge core_clk);
        #1 `CHK({dev_ready, write_busy}, 2'h0)
        @(posedge core_clk) rst_n <= 1'b1;
        repeat (18) @(posedge core_clk);
        #1 `CHK(dev_ready, 1'b0)
        repeat (4) @(posedge core_clk);
        #1 `CHK(dev_ready, 1'b1)
    endtask
    task automatic addr_load(input logic [15:0] a);
        logic k;
        logic [23:0] f;
        f = {DEV_W, a};
        bus_master_inst.start();
        for (int i = 0; i < 3; i++) begin
            bus_master_inst.wbyte(f[23 - 8 * i -: 8], k);
            `CHK(k, 1'b1)
        end
    endtask
    task automatic read_at(input logic ld, input logic [15:0] a, input int n);
        logic k;
        logic [7:0] d;
        got = {};
        if (ld) addr_load(a);
        bus_master_inst.start(); // repeated start after a load
        bus_master_inst.wbyte(DEV_R, k);
        `CHK(k, 1'b1)
        for (int i = 0; i < n; i++) begin
            bus_master_inst.rbyte(i < n - 1, d);
            got.push_back(d);
        end
        bus_master_inst.stop();
    endtask
    task automatic write_at(input logic [15:0] a, input int n, input logic [7:0] v);
        logic k;
        addr_load(a);
        for (int i = 0; i < n; i++) begin
            bus_master_inst.wbyte(v + i[7:0], k);
            `CHK(k, 1'b1)
        end
        bus_master_inst.stop();
    endtask
    // reissue the address until the target answers again
    task automatic poll_done();
        logic k;
        int n;
        k = 1'b0;
        for (n = 0; n < 40 && !k; n++) begin
            bus_master_inst.start();
            bus_master_inst.wbyte(DEV_W, k);
            bus_master_inst.stop();
            if (n == 0) `CHK(k, 1'b0)
        end
        `CHK(k, 1'b1)
    endtask
    task automatic sel_check();
        logic k;
        for (int s = 0; s < 8; s++) begin
            @(posedge core_clk) strap_lvl <= s[2:0];
            bus_master_inst.start();
            bus_master_inst.wbyte(DEV_W, k);
            bus_master_inst.stop();
            `CHK(k, s == 5)
        end
        @(posedge core_clk) strap_lvl <= 3'h5;
        bus_master_inst.start();
        bus_master_inst.wbyte(8'h5a, k);
        `CHK(k, 1'b0)
        bus_master_inst.stop();
        bus_master_inst.wbyte(DEV_W, k);
        `CHK(k, 1'b0)
        bus_master_inst.stop();
    endtask
    task automatic erased_check();
        read_at(1'b0, 16'h0000, 1);
        `CHK(got[0], `ERASED_BYTE)
    endtask
    task automatic byte_check();
        write_at(16'he000, 1, 8'h5a); // top address bits are ignored
        poll_done();
        read_at(1'b1, 16'h0000, 1);
        `CHK(got[0], 8'h5a)
        read_at(1'b1, 16'h1fff, 2);
        `CHK({got[0], got[1]}, 16'hff5a)
    endtask
    task automatic page_check();
        write_at(16'h005e, 3, 8'h10);
        poll_done();
        read_at(1'b1, 16'h005d, 1);
        read_at(1'b0, 16'h0000, 2);
        `CHK({got[0], got[1]}, 16'h1011)
        read_at(1'b1, 16'h0040, 2);
        `CHK({got[0], got[1]}, 16'h12ff)
        read_at(1'b1, 16'h005e, 1);
        read_at(1'b0, 16'h0000, 1);
        `CHK(got[0], 8'h11)
    endtask
    task automatic protect_check();
        logic k;
        @(posedge core_clk) wp_lvl <= 1'b1;
        addr_load(16'h0100);
        bus_master_inst.wbyte(8'h77, k);
        `CHK(k, 1'b0)
        bus_master_inst.stop();
        repeat (20) @(posedge core_clk);
        #1 `CHK(write_busy, 1'b0)
        @(posedge core_clk) wp_lvl <= 1'b0;
        read_at(1'b1, 16'h0100, 1);
        `CHK(got[0], `ERASED_BYTE)
    endtask
    // second reset mid-run: array kept, address back at zero
    task automatic rereset_check();
        power_up();
        read_at(1'b0, 16'h0000, 1);
        `CHK(got[0], 8'h5a)
    endtask
    initial begin
        rst_n = 1'b0;
        wp_lvl = 1'b0;
        strap_lvl = 3'h5;
        n_checks = 0;
        err_total = 0;
        power_up();
        sel_check();
        erased_check();
        byte_check();
        page_check();
        protect_check();
        rereset_check();
        give_verdict();
    end
    // the sequence needs far under this span; a hang ends here
    initial begin
        #900000;
        err_total++;
        give_verdict();
    end
endmodule // i2c_eeprom_slave_bench
`default_nettype wire
